/* File: verilog/rtu_timer_irq.sv */
// timer unit with four counting timers, a wake-up timer and interrupt controller
//
// Function
// - two flag registers, two enable registers, seven bits
// - bit 7 selects set or clear of bits 0-6
// - event sets status irq bit and request pin
// - timer underflow sets its own flag
// - transmitter end-of-frame start sets transmit-done flag
// - end of received stream sets receive-done flag
// - command going idle sets idle flag
// - one water level for both FIFO thresholds
// - FIFO level rising edges set alert flags
// - any receive error bit sets error flag
// - start of frame and card detect set flags
// - any enabled flag sets the global flag
// - timer clock: fast, slow or wake underflow
// - 16-bit counter, reload split high/low bytes
// - wake timer on oscillator, auto-wake returns standby
// - global start/stop bits, running reads back
// - decrement per tick, count readable as bytes
// - interrupt on the tick after zero
// - host may set and clear timer flags
// - underflow halts or reloads when auto-reload set
// - own control register start configuration starts timer
// - stop event halts timer, holds count, no flag
`timescale 1ns/1ps

module rtu_timer_irq
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // host register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // event sources, same clock domain
  input wire logic tx_eof_start,
  input wire logic rx_stream_end,
  input wire logic cmd_went_idle,
  input wire logic rx_sof_seen,
  input wire logic [7:0] rx_error_bits,
  input wire logic [9:0] fifo_count,
  input wire logic card_found,
  input wire logic card_search_empty,
  input wire logic timer_start_event,
  input wire logic timer_stop_event,
  // low-frequency oscillator pin, asynchronous
  input wire logic low_freq_osc,
  // outputs
  output logic irq_req,
  output logic standby_req
);

  // ==========================================================================
  // decode helpers
  function automatic logic timer_hit(input logic [7:0] addr, input int idx,
                                     input logic [7:0] ofs);
    timer_hit = addr == 8'(rtu_pkg::ADDR_TIMER_BASE + 8'(idx) * rtu_pkg::TIMER_STRIDE + ofs);
  endfunction

  // bit 7 of the written byte picks set or clear for the ones in bits 0-6
  function automatic logic [6:0] apply_write(input logic [6:0] old, input logic [7:0] wd);
    apply_write = wd[rtu_pkg::BIT_SET_CLEAR] ? (old | wd[6:0]) : (old & ~wd[6:0]);
  endfunction

  // ==========================================================================
  // clock enables from fractional dividers
  localparam logic [14:0] ACC_MOD = 15'(rtu_pkg::SYS_CLK_KHZ);
  localparam logic [14:0] FAST_STEP = 15'(rtu_pkg::FAST_CLK_KHZ);
  localparam logic [14:0] SLOW_STEP = 15'(rtu_pkg::SLOW_CLK_KHZ);

  logic [14:0] fast_acc;
  logic [14:0] slow_acc;
  logic tick_fast;
  logic tick_slow;
  wire [15:0] fast_sum = {1'b0, fast_acc} + {1'b0, FAST_STEP};
  wire [15:0] slow_sum = {1'b0, slow_acc} + {1'b0, SLOW_STEP};
  wire fast_wrap = fast_sum >= {1'b0, ACC_MOD};
  wire slow_wrap = slow_sum >= {1'b0, ACC_MOD};

  // average rate is exact; edges jitter by one system clock
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fast_acc <= 15'h0000;
      slow_acc <= 15'h0000;
      tick_fast <= 1'b0;
      tick_slow <= 1'b0;
    end
    else
    begin
      fast_acc <= fast_wrap ? 15'(fast_sum - {1'b0, ACC_MOD}) : fast_sum[14:0];
      slow_acc <= slow_wrap ? 15'(slow_sum - {1'b0, ACC_MOD}) : slow_sum[14:0];
      tick_fast <= fast_wrap;
      tick_slow <= slow_wrap;
    end
  end

  // ==========================================================================
  // oscillator pin synchroniser and edge detect
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  wire lfo_tick = osc_sync & ~osc_prev;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_meta <= low_freq_osc;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // ==========================================================================
  // global register strobes
  wire wr_flags_a = reg_wr && reg_addr == rtu_pkg::ADDR_FLAGS_A;
  wire wr_flags_b = reg_wr && reg_addr == rtu_pkg::ADDR_FLAGS_B;
  wire wr_enable_a = reg_wr && reg_addr == rtu_pkg::ADDR_ENABLE_A;
  wire wr_enable_b = reg_wr && reg_addr == rtu_pkg::ADDR_ENABLE_B;
  wire wr_global = reg_wr && reg_addr == rtu_pkg::ADDR_TIMER_GLOBAL;
  wire wr_water = reg_wr && reg_addr == rtu_pkg::ADDR_WATER_LEVEL;
  wire wr_pin_ctrl = reg_wr && reg_addr == rtu_pkg::ADDR_IRQ_PIN_CTRL;

  // ==========================================================================
  // timers
  logic [15:0] t_count [0:rtu_pkg::NUM_TIMERS-1];
  logic [15:0] t_reload [0:rtu_pkg::NUM_TIMERS-1];
  logic [7:0] t_ctrl [0:rtu_pkg::NUM_TIMERS-1];
  logic [7:0] t_rd [0:rtu_pkg::NUM_TIMERS-1];
  logic [rtu_pkg::NUM_TIMERS-1:0] t_running;
  logic [rtu_pkg::NUM_TIMERS-1:0] t_underflow;
  logic wake_uf_q;

  genvar n;
  generate
    for (n = 0; n < rtu_pkg::NUM_TIMERS; n++)
    begin : g_timer
      wire wr_ctrl = reg_wr && timer_hit(reg_addr, n, rtu_pkg::TOFS_CTRL);
      wire wr_rl_hi = reg_wr && timer_hit(reg_addr, n, rtu_pkg::TOFS_RELOAD_HIGH);
      wire wr_rl_lo = reg_wr && timer_hit(reg_addr, n, rtu_pkg::TOFS_RELOAD_LOW);
      wire rd_ctrl = timer_hit(reg_addr, n, rtu_pkg::TOFS_CTRL);
      wire rd_rl_hi = timer_hit(reg_addr, n, rtu_pkg::TOFS_RELOAD_HIGH);
      wire rd_rl_lo = timer_hit(reg_addr, n, rtu_pkg::TOFS_RELOAD_LOW);
      wire rd_ct_hi = timer_hit(reg_addr, n, rtu_pkg::TOFS_COUNT_HIGH);
      wire rd_ct_lo = timer_hit(reg_addr, n, rtu_pkg::TOFS_COUNT_LOW);
      wire rtu_pkg::rtu_clk_sel_type sel =
        rtu_pkg::rtu_clk_sel_type'(t_ctrl[n][rtu_pkg::CTRL_CLK_LSB +: 2]);
      wire sel_tick = (sel == rtu_pkg::RTU_CLK_FAST) ? tick_fast :
                      (sel == rtu_pkg::RTU_CLK_SLOW) ? tick_slow :
                      (sel == rtu_pkg::RTU_CLK_WAKE) ? wake_uf_q : 1'b0;
      wire tick;
      wire start_now;
      wire stop_now;

      if (n == rtu_pkg::WAKE_IDX)
      begin : g_wake
        // wake timer always counts rising oscillator edges; control bit 3 runs it
        assign tick = lfo_tick;
        assign start_now = wr_ctrl & reg_wdata[rtu_pkg::CTRL_START_EVT] & ~t_running[n];
        assign stop_now = wr_ctrl & ~reg_wdata[rtu_pkg::CTRL_START_EVT];
      end
      else
      begin : g_main
        wire glob_sel = wr_global & reg_wdata[rtu_pkg::TG_START_STOP_LSB + n];
        assign tick = sel_tick;
        assign start_now = (glob_sel & reg_wdata[n]) |
                           (t_ctrl[n][rtu_pkg::CTRL_START_EVT] & timer_start_event &
                            ~t_running[n]);
        assign stop_now = (glob_sel & ~reg_wdata[n]) |
                          (t_ctrl[n][rtu_pkg::CTRL_STOP_EVT] & timer_stop_event &
                           t_running[n]);
      end

      wire at_zero = t_count[n] == 16'h0000;
      // start and stop outrank a tick in the same cycle; a stop never flags
      assign t_underflow[n] = t_running[n] & tick & at_zero & ~start_now & ~stop_now;

      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          t_ctrl[n] <= rtu_pkg::RST_BYTE;
          t_reload[n] <= rtu_pkg::RST_WORD;
        end
        else
        begin
          if (wr_ctrl)
            t_ctrl[n] <= reg_wdata;
          if (wr_rl_hi)
            t_reload[n][15:8] <= reg_wdata;
          if (wr_rl_lo)
            t_reload[n][7:0] <= reg_wdata;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          t_count[n] <= rtu_pkg::RST_WORD;
          t_running[n] <= 1'b0;
        end
        else if (start_now)
        begin
          t_count[n] <= t_reload[n];
          t_running[n] <= 1'b1;
        end
        else if (stop_now)
          t_running[n] <= 1'b0;
        else if (t_underflow[n])
        begin
          if (t_ctrl[n][rtu_pkg::CTRL_AUTO_RELOAD])
            t_count[n] <= t_reload[n];
          else
            t_running[n] <= 1'b0;
        end
        else if (t_running[n] & tick)
          t_count[n] <= t_count[n] - 16'h0001;
      end

      assign t_rd[n] = rd_ctrl ? t_ctrl[n] :
                       rd_rl_hi ? t_reload[n][15:8] :
                       rd_rl_lo ? t_reload[n][7:0] :
                       rd_ct_hi ? t_count[n][15:8] :
                       rd_ct_lo ? t_count[n][7:0] : 8'h00;
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_uf_q <= 1'b0;
    else
      wake_uf_q <= t_underflow[rtu_pkg::WAKE_IDX];
  end

  // ==========================================================================
  // FIFO thresholds and level-change detection
  logic [7:0] water_level;
  logic fifo_high_level_q;
  logic fifo_low_level_q;
  logic error_any_q;
  wire [9:0] fifo_free = rtu_pkg::FIFO_DEPTH - fifo_count;
  wire fifo_high_level = fifo_free <= {2'b00, water_level};
  wire fifo_low_level = fifo_count <= {2'b00, water_level};
  wire error_any = |rx_error_bits;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fifo_high_level_q <= 1'b0;
      fifo_low_level_q <= 1'b0;
      error_any_q <= 1'b0;
    end
    else
    begin
      fifo_high_level_q <= fifo_high_level;
      fifo_low_level_q <= fifo_low_level;
      error_any_q <= error_any;
    end
  end

  // ==========================================================================
  // interrupt controller
  logic [6:0] irq_flags_a;
  logic [6:0] irq_flags_b;
  logic [6:0] irq_enable_a;
  logic [6:0] irq_enable_b;
  logic irq_pin_enable;

  wire [6:0] hw_set_a;
  assign hw_set_a[rtu_pkg::FA_TRANSMIT_DONE] = tx_eof_start;
  assign hw_set_a[rtu_pkg::FA_RECEIVE_DONE] = rx_stream_end;
  assign hw_set_a[rtu_pkg::FA_IDLE] = cmd_went_idle;
  assign hw_set_a[rtu_pkg::FA_FIFO_HIGH] = fifo_high_level & ~fifo_high_level_q;
  assign hw_set_a[rtu_pkg::FA_FIFO_LOW] = fifo_low_level & ~fifo_low_level_q;
  assign hw_set_a[rtu_pkg::FA_ERROR] = error_any & ~error_any_q;
  assign hw_set_a[rtu_pkg::FA_START_OF_FRAME] = rx_sof_seen;

  wire other_pending = |(irq_flags_a & irq_enable_a) |
                       |(irq_flags_b[5:0] & irq_enable_b[5:0]);
  wire [6:0] hw_set_b;
  assign hw_set_b[3:0] = t_underflow[3:0];
  assign hw_set_b[rtu_pkg::FB_WAKE_TIMER] = t_underflow[rtu_pkg::WAKE_IDX];
  assign hw_set_b[rtu_pkg::FB_CARD_DETECT] = card_found;
  assign hw_set_b[rtu_pkg::FB_ANY_SOURCE] = other_pending;

  // hardware set wins over a host clear in the same cycle
  wire [6:0] next_flags_a = (wr_flags_a ? apply_write(irq_flags_a, reg_wdata) : irq_flags_a) |
                            hw_set_a;
  wire [6:0] next_flags_b = (wr_flags_b ? apply_write(irq_flags_b, reg_wdata) : irq_flags_b) |
                            hw_set_b;
  wire [6:0] next_enable_a = wr_enable_a ? apply_write(irq_enable_a, reg_wdata) : irq_enable_a;
  wire [6:0] next_enable_b = wr_enable_b ? apply_write(irq_enable_b, reg_wdata) : irq_enable_b;
  wire pending = |(irq_flags_a & irq_enable_a) | |(irq_flags_b & irq_enable_b);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_flags_a <= 7'h00;
      irq_flags_b <= 7'h00;
      irq_enable_a <= 7'h00;
      irq_enable_b <= 7'h00;
    end
    else
    begin
      irq_flags_a <= next_flags_a;
      irq_flags_b <= next_flags_b;
      irq_enable_a <= next_enable_a;
      irq_enable_b <= next_enable_b;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      water_level <= rtu_pkg::RST_WATER_LEVEL;
      irq_pin_enable <= 1'b0;
      irq_req <= 1'b0;
    end
    else
    begin
      if (wr_water)
        water_level <= reg_wdata;
      if (wr_pin_ctrl)
        irq_pin_enable <= reg_wdata[0];
      irq_req <= pending & irq_pin_enable;
    end
  end

  // ==========================================================================
  // standby control for low-power card detection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      standby_req <= 1'b0;
    else if (t_underflow[rtu_pkg::WAKE_IDX])
      standby_req <= 1'b0;
    else if (card_search_empty & t_ctrl[rtu_pkg::WAKE_IDX][rtu_pkg::CTRL_AUTO_WAKE])
      standby_req <= 1'b1;
  end

  // ==========================================================================
  // read path, data one cycle after the strobe; unmapped reads give zero
  wire [7:0] status_one = {6'h00, standby_req, pending};
  wire [7:0] global_rd = {4'h0, t_running[3:0]};
  logic [7:0] timers_rd;

  always_comb
  begin
    timers_rd = 8'h00;
    for (int i = 0; i < rtu_pkg::NUM_TIMERS; i++)
      timers_rd = timers_rd | t_rd[i];
  end

  wire [7:0] rd_mux =
    (reg_addr == rtu_pkg::ADDR_STATUS_ONE) ? status_one :
    (reg_addr == rtu_pkg::ADDR_FLAGS_A) ? {1'b0, irq_flags_a} :
    (reg_addr == rtu_pkg::ADDR_FLAGS_B) ? {1'b0, irq_flags_b} :
    (reg_addr == rtu_pkg::ADDR_ENABLE_A) ? {1'b0, irq_enable_a} :
    (reg_addr == rtu_pkg::ADDR_ENABLE_B) ? {1'b0, irq_enable_b} :
    (reg_addr == rtu_pkg::ADDR_TIMER_GLOBAL) ? global_rd :
    (reg_addr == rtu_pkg::ADDR_WATER_LEVEL) ? water_level :
    (reg_addr == rtu_pkg::ADDR_IRQ_PIN_CTRL) ? {7'h00, irq_pin_enable} : timers_rd;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

endmodule // rtu_timer_irq

/* File: verilog/rtu_pkg.sv */
// constants and types for the reader timer unit with interrupt controller
package rtu_pkg;

  // ==========================================================================
  // register map (byte addresses on the host port)
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_A = 8'h01;
  localparam logic [7:0] ADDR_FLAGS_B = 8'h02;
  localparam logic [7:0] ADDR_ENABLE_A = 8'h03;
  localparam logic [7:0] ADDR_ENABLE_B = 8'h04;
  localparam logic [7:0] ADDR_TIMER_GLOBAL = 8'h05;
  localparam logic [7:0] ADDR_WATER_LEVEL = 8'h06;
  localparam logic [7:0] ADDR_IRQ_PIN_CTRL = 8'h07;
  localparam logic [7:0] ADDR_TIMER_BASE = 8'h10;
  localparam logic [7:0] TIMER_STRIDE = 8'h08;
  localparam logic [7:0] TOFS_CTRL = 8'h00;
  localparam logic [7:0] TOFS_RELOAD_HIGH = 8'h01;
  localparam logic [7:0] TOFS_RELOAD_LOW = 8'h02;
  localparam logic [7:0] TOFS_COUNT_HIGH = 8'h03;
  localparam logic [7:0] TOFS_COUNT_LOW = 8'h04;

  // ==========================================================================
  // field positions
  localparam int BIT_SET_CLEAR = 7;
  localparam int FA_TRANSMIT_DONE = 0;
  localparam int FA_RECEIVE_DONE = 1;
  localparam int FA_IDLE = 2;
  localparam int FA_FIFO_HIGH = 3;
  localparam int FA_FIFO_LOW = 4;
  localparam int FA_ERROR = 5;
  localparam int FA_START_OF_FRAME = 6;
  localparam int FB_WAKE_TIMER = 4;
  localparam int FB_CARD_DETECT = 5;
  localparam int FB_ANY_SOURCE = 6;
  localparam int TG_START_STOP_LSB = 4;
  localparam int CTRL_CLK_LSB = 0;
  localparam int CTRL_AUTO_RELOAD = 2;
  localparam int CTRL_START_EVT = 3;
  localparam int CTRL_STOP_EVT = 4;
  localparam int CTRL_AUTO_WAKE = 5;
  localparam int ST_IRQ = 0;
  localparam int ST_STANDBY = 1;

  // ==========================================================================
  // reset values, sizes, timing
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_WATER_LEVEL = 8'h08;
  localparam logic [9:0] FIFO_DEPTH = 10'h200;
  localparam int NUM_TIMERS = 5;
  localparam int WAKE_IDX = 4;
  localparam int SYS_CLK_KHZ = 25000;
  localparam int FAST_CLK_KHZ = 13560;
  localparam int SLOW_CLK_KHZ = 212;

  typedef enum logic [1:0] {
    RTU_CLK_FAST = 2'b00,
    RTU_CLK_SLOW = 2'b01,
    RTU_CLK_WAKE = 2'b10,
    RTU_CLK_NONE = 2'b11
  } rtu_clk_sel_type;

endpackage

/* File: test/rtu_timer_irq_asserts.sv */
// port-level assertions for the timer unit with interrupt controller
`timescale 1ns/1ps

module rtu_timer_irq_asserts
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // event and outputs
  input wire logic card_search_empty,
  input wire logic irq_req,
  input wire logic standby_req
);
  logic rd_q;
  logic [7:0] a_q;
  logic pin_sh;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // helper state: last strobe and the pin enable as the host wrote it
  always_ff @(posedge clk_sys)
  begin
    rd_q <= reg_rd && !sys_rst;
    a_q <= reg_addr;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pin_sh <= 1'b0;
    else if (reg_wr && reg_addr == rtu_pkg::ADDR_IRQ_PIN_CTRL)
      pin_sh <= reg_wdata[0];
  end

  // ==========================================================================
  // checks
  a_rdata_one_cycle: assert property (!rd_q |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_flag_bit7_zero: assert property (
    rd_q && a_q inside {[8'h01:8'h04]} |-> !reg_rdata[7])
    else $error("bit 7 of flag or enable read as one");
  a_unmapped_zero: assert property (
    rd_q && (a_q inside {[8'h08:8'h0F]} || a_q >= 8'h38) |-> reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_status_standby: assert property (
    rd_q && a_q == rtu_pkg::ADDR_STATUS_ONE |-> reg_rdata[1] == $past(standby_req))
    else $error("status standby bit differs from output");
  a_pending_gate: assert property (
    rd_q && a_q == rtu_pkg::ADDR_STATUS_ONE && !reg_rdata[0] |-> !irq_req)
    else $error("request pin high with nothing pending");
  a_irq_needs_pin: assert property (irq_req |-> $past(pin_sh))
    else $error("request pin high while pin disabled");
  a_standby_cause: assert property (
    $rose(standby_req) |-> $past(card_search_empty) || $past(card_search_empty, 2))
    else $error("standby without empty search");
  a_reset_quiet: assert property (
    $past(sys_rst) |-> !irq_req && !standby_req && reg_rdata == 8'h00)
    else $error("outputs active after reset");
endmodule // rtu_timer_irq_asserts

bind rtu_timer_irq rtu_timer_irq_asserts rtu_timer_irq_asserts_inst
(
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .card_search_empty(card_search_empty),
  .irq_req(irq_req),
  .standby_req(standby_req)
);

/* File: test/rtu_host_model.sv */
// host microcontroller model driving the register port
`timescale 1ns/1ps

module rtu_host_model
(
  // clock
  input wire logic clk_sys,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // released data must not keep looking valid
    reg_wdata <= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask

  // start_stop_now with running set starts, with running clear stops
  task automatic timer_run(input int n, input logic run);
    wr(rtu_pkg::ADDR_TIMER_GLOBAL, 8'(8'h10 << n) | 8'({7'h00, run} << n));
  endtask
endmodule // rtu_host_model

/* File: test/tb_top.sv */
// self-checking bench for the timer unit with interrupt controller
`timescale 1ns/1ps

module tb_top;
  logic clk_sys;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] ev;
  logic [7:0] rx_error_bits;
  logic [9:0] fifo_count;
  logic low_freq_osc;
  logic irq_req;
  logic standby_req;
  logic [7:0] d;
  logic [7:0] ea;
  int failures;
  int n_tests;
  int seed;

  rtu_timer_irq rtu_timer_irq_inst
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .tx_eof_start(ev[0]),
    .rx_stream_end(ev[1]),
    .cmd_went_idle(ev[2]),
    .rx_sof_seen(ev[6]),
    .rx_error_bits(rx_error_bits),
    .fifo_count(fifo_count),
    .card_found(ev[3]),
    .card_search_empty(ev[7]),
    .timer_start_event(ev[4]),
    .timer_stop_event(ev[5]),
    .low_freq_osc(low_freq_osc),
    .irq_req(irq_req),
    .standby_req(standby_req)
  );

  rtu_host_model rtu_host_model_inst
  (
    .clk_sys(clk_sys),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // oscillator is unrelated to the system clock
  initial
  begin
    low_freq_osc = 1'b0;
    #7;
    forever #200 low_freq_osc = ~low_freq_osc;
  end

  // ==========================================================================
  // helpers
  function automatic logic [7:0] setclr(input logic [7:0] old, input logic [7:0] w);
    return w[7] ? (old | {1'b0, w[6:0]}) : (old & ~{1'b0, w[6:0]});
  endfunction

  function automatic logic [7:0] ta(input int n, input int o);
    return rtu_pkg::ADDR_TIMER_BASE + 8'(n * rtu_pkg::TIMER_STRIDE + o);
  endfunction

  // expected count low byte after so many system cycles on the slow clock
  function automatic logic [7:0] slow_low(input int c, input logic [7:0] r);
    return r - 8'((c * rtu_pkg::SLOW_CLK_KHZ) / rtu_pkg::SYS_CLK_KHZ);
  endfunction

  task automatic end_sim;
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t read 0x%h expected 0x%h", $time, g, e);
    end
  endtask

  task automatic pchk(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t pin %b expected %b", $time, g, e);
    end
  endtask

  task automatic rng(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
    n_tests++;
    if (!(g >= lo && g <= hi) || $isunknown(g))
    begin
      failures++;
      $display("[ERR] %0t read 0x%h outside 0x%h..0x%h", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    rtu_host_model_inst.wr(a, v);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    rtu_host_model_inst.rd(a, g);
    chk(g, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev[k] <= 1'b1;
    @(posedge clk_sys);
    ev[k] <= 1'b0;
  endtask

  task automatic clr_flags;
    wr(rtu_pkg::ADDR_FLAGS_A, 8'h7F);
    wr(rtu_pkg::ADDR_FLAGS_B, 8'h7F);
  endtask

  task automatic fifo_step(input logic [9:0] c, input logic [7:0] e);
    @(posedge clk_sys);
    fifo_count <= c;
    cyc(3);
    rchk(rtu_pkg::ADDR_FLAGS_A, e);
    clr_flags();
  endtask

  initial
  begin
    #(40 * 30000);
    failures++;
    end_sim();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    seed = 34134;
    failures = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    ev = 8'h00;
    rx_error_bits = 8'h00;
    fifo_count = 10'h064;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk(rtu_pkg::ADDR_STATUS_ONE, 8'h00);
    rchk(rtu_pkg::ADDR_WATER_LEVEL, 8'h08);
    rchk(8'h0A, 8'h00);
    rchk(8'h40, 8'h00);
    ea = 8'h00;
    repeat (12)
    begin
      d = 8'($random(seed));
      wr(rtu_pkg::ADDR_ENABLE_A, d);
      ea = setclr(ea, d);
      rchk(rtu_pkg::ADDR_ENABLE_A, ea);
    end
    wr(rtu_pkg::ADDR_ENABLE_A, 8'h7F);
    for (int i = 0; i < 7; i++)
    begin
      if (i inside {0, 1, 2, 6})
      begin
        pulse(i);
        rchk(rtu_pkg::ADDR_FLAGS_A, 8'h01 << i);
        clr_flags();
      end
    end
    @(posedge clk_sys);
    rx_error_bits <= 8'h20;
    cyc(3);
    rchk(rtu_pkg::ADDR_FLAGS_A, 8'h20);
    @(posedge clk_sys);
    rx_error_bits <= 8'h00;
    clr_flags();
    fifo_step(10'h009, 8'h00);
    fifo_step(10'h008, 8'h10);
    fifo_step(10'h1F8, 8'h08);
    fifo_step(10'h064, 8'h00);
    // a programmed level moves both thresholds, not only the reset one
    wr(rtu_pkg::ADDR_WATER_LEVEL, 8'h20);
    rchk(rtu_pkg::ADDR_WATER_LEVEL, 8'h20);
    fifo_step(10'h021, 8'h00);
    fifo_step(10'h020, 8'h10);
    fifo_step(10'h1E0, 8'h08);
    fifo_step(10'h064, 8'h00);
    pulse(3);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h20);
    clr_flags();
    wr(rtu_pkg::ADDR_ENABLE_A, 8'h81);
    wr(rtu_pkg::ADDR_IRQ_PIN_CTRL, 8'h01);
    pulse(0);
    cyc(3);
    pchk(irq_req, 1'b1);
    rchk(rtu_pkg::ADDR_STATUS_ONE, 8'h01);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h40);
    wr(rtu_pkg::ADDR_FLAGS_A, 8'h01);
    wr(rtu_pkg::ADDR_FLAGS_B, 8'h40);
    cyc(2);
    pchk(irq_req, 1'b0);
    wr(rtu_pkg::ADDR_FLAGS_B, 8'h81);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h01);
    wr(rtu_pkg::ADDR_ENABLE_B, 8'h81);
    cyc(2);
    pchk(irq_req, 1'b1);
    wr(rtu_pkg::ADDR_ENABLE_B, 8'h01);
    cyc(2);
    pchk(irq_req, 1'b0);
    wr(rtu_pkg::ADDR_IRQ_PIN_CTRL, 8'h00);
    wr(rtu_pkg::ADDR_ENABLE_A, 8'h7F);
    clr_flags();
    wr(ta(0, 2), 8'h05);
    rtu_host_model_inst.timer_run(0, 1'b1);
    rchk(rtu_pkg::ADDR_TIMER_GLOBAL, 8'h01);
    cyc(40);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h01);
    rchk(rtu_pkg::ADDR_TIMER_GLOBAL, 8'h00);
    rchk(ta(0, 4), 8'h00);
    clr_flags();
    wr(ta(3, 2), 8'h03);
    wr(ta(3, 0), 8'h04);
    rtu_host_model_inst.timer_run(3, 1'b1);
    cyc(40);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h08);
    rchk(rtu_pkg::ADDR_TIMER_GLOBAL, 8'h08);
    rtu_host_model_inst.timer_run(3, 1'b0);
    rchk(rtu_pkg::ADDR_TIMER_GLOBAL, 8'h00);
    clr_flags();
    wr(ta(2, 1), 8'h12);
    wr(ta(2, 2), 8'h34);
    wr(ta(2, 0), 8'h11);
    rtu_host_model_inst.timer_run(2, 1'b1);
    rchk(ta(2, 3), 8'h12);
    cyc(1180);
    pulse(5);
    rchk(rtu_pkg::ADDR_TIMER_GLOBAL, 8'h00);
    cyc(600);
    rtu_host_model_inst.rd(ta(2, 4), d);
    rng(d, slow_low(1184, 8'h34) - 8'h01, slow_low(1184, 8'h34) + 8'h01);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h00);
    wr(ta(1, 2), 8'hAB);
    wr(ta(1, 0), 8'h0B);
    pulse(4);
    rchk(rtu_pkg::ADDR_TIMER_GLOBAL, 8'h02);
    rchk(ta(1, 4), 8'hAB);
    rtu_host_model_inst.timer_run(1, 1'b0);
    wr(ta(1, 2), 8'h01);
    wr(ta(1, 0), 8'h02);
    rtu_host_model_inst.timer_run(1, 1'b1);
    wr(ta(4, 2), 8'h01);
    wr(ta(4, 0), 8'h2C);
    pulse(7);
    cyc(2);
    pchk(standby_req, 1'b1);
    cyc(150);
    pchk(standby_req, 1'b0);
    rchk(rtu_pkg::ADDR_FLAGS_B, 8'h12);
    wr(ta(4, 0), 8'h00);
    end_sim();
  end
endmodule // tb_top
